/* include/rcs_rom_security_regs.svh */
/*
 * register offsets, field positions and reset values for
 * the rom code security block.
 * assumes apb byte addressing with one aligned 32-bit word per register.
 */
`ifndef RCS_ROM_SECURITY_REGS_SVH
`define RCS_ROM_SECURITY_REGS_SVH

// apb register byte offsets
`define RCS_OFF_CTRL 4'h0
`define RCS_OFF_STATUS 4'h4
`define RCS_OFF_WORD 4'h8

// rom geometry
`define RCS_ROM_AW 15
`define RCS_ROM_DW 17
`define RCS_PROT_WORD_ADDR 15'h7ffe
`define RCS_ERASED_WORD 17'h1_ffff

// protection word fields
`define RCS_TRUE_HI 14
`define RCS_TRUE_LO 9
`define RCS_GLOBAL_BIT 8
`define RCS_BLOCK_BIT 7
`define RCS_INV_HI 5
`define RCS_INV_LO 0
`define RCS_GLOBAL_MASK 17'h0_0100

// partition index sits in address bits 14..9 (512-word granule)
`define RCS_PART_HI 14
`define RCS_PART_LO 9

// ctrl fields
`define RCS_CTRL_MODE_HI 1
`define RCS_CTRL_MODE_LO 0
`define RCS_CTRL_REINIT 2

// status fields
`define RCS_ST_MODE_HI 1
`define RCS_ST_MODE_LO 0
`define RCS_ST_BUSY 2
`define RCS_ST_PROT_HI 4
`define RCS_ST_PROT_LO 3

`endif

/* include/rcs_pkg.sv */
/*
 * types shared by the rom code security block.
 * assumes rcs_rom_security_regs.svh supplies the numeric constants.
 */
package rcs_pkg;
   // init sequencer, one bit changes per step except run back to read
   typedef enum logic [1:0] {
      RCS_ST_READ = 2'b00,
      RCS_ST_CAPT = 2'b01,
      RCS_ST_RUN = 2'b11
   } rcs_state_t;

   // operating modes of the processor
   typedef enum logic [1:0] {
      RCS_MODE_NORMAL = 2'b00,
      RCS_MODE_EPROM = 2'b01,
      RCS_MODE_EMUL = 2'b10,
      RCS_MODE_TRACE = 2'b11
   } rcs_mode_t;

   // decoded security state
   typedef enum logic [1:0] {
      RCS_PROT_NONE = 2'b00,
      RCS_PROT_BLOCK = 2'b01,
      RCS_PROT_GLOBAL = 2'b10
   } rcs_prot_t;
endpackage

/* src/rcs_rom_security.sv */
/*
 * rom code security: latches the protection word from rom after reset
 * and before every mode change or reinit written to ctrl while running, stalls the core
 * meanwhile, and grants or denies scan accesses and lookup instructions.
 * assumes the rom array returns read data one cycle after rom_rd_en and
 * an apb master on pclk.
 */
// The implementer's own choice: the APB register port.
`timescale 1ns/100ps
`include "rcs_rom_security_regs.svh"

module rcs_rom_security (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [`RCS_ROM_AW-1:0] rom_addr,
   output logic rom_rd_en,
   input wire logic [`RCS_ROM_DW-1:0] rom_rdata,
   output logic core_stall,
   input wire logic vpp_low,
   input wire logic scan_req,
   input wire logic scan_we,
   input wire logic [`RCS_ROM_AW-1:0] scan_addr,
   input wire logic [`RCS_ROM_DW-1:0] scan_wdata,
   output logic scan_grant,
   output logic scan_deny,
   input wire logic lookup_req,
   input wire logic [`RCS_ROM_AW-1:0] lookup_instr_addr,
   input wire logic [`RCS_ROM_AW-1:0] lookup_data_addr,
   output logic lookup_ok,
   output logic lookup_fault,
   output logic lookup_external,
   output logic [1:0] mode
);

   rcs_pkg::rcs_state_t state_r, state_nxt;
   rcs_pkg::rcs_mode_t mode_r, mode_nxt, pend_mode_r, pend_mode_nxt;
   logic [`RCS_ROM_DW-1:0] word_r;
   logic rd_en_r;
   logic scan_grant_r, scan_deny_r;
   logic lookup_ok_r, lookup_fault_r, lookup_ext_r;
   logic [31:0] prdata_r;
   logic pready_r, pslverr_r;

   // field views of the latched protection word
   wire logic [5:0] partition_index =
      word_r[`RCS_TRUE_HI:`RCS_TRUE_LO];
   wire logic [5:0] inverse_partition_marker =
      word_r[`RCS_INV_HI:`RCS_INV_LO];
   wire logic global_lock_n = word_r[`RCS_GLOBAL_BIT];
   wire logic block_lock_n = word_r[`RCS_BLOCK_BIT];
   // reserved bits 6, 15, 16 are not decoded, so any value is tolerated
   wire logic parity_ok =
      (inverse_partition_marker == ~partition_index);

   // security state; under block lock a broken marker pair falls back to full protection
   wire rcs_pkg::rcs_prot_t prot =
      !global_lock_n ? rcs_pkg::RCS_PROT_GLOBAL :
      !block_lock_n ? (parity_ok ? rcs_pkg::RCS_PROT_BLOCK
                                 : rcs_pkg::RCS_PROT_GLOBAL) :
      rcs_pkg::RCS_PROT_NONE;
   wire logic running = (state_r == rcs_pkg::RCS_ST_RUN);

   // lower block is index 0..partition_index of 512-word granules
   wire logic scan_lower =
      scan_addr[`RCS_PART_HI:`RCS_PART_LO] <= partition_index;
   wire logic lk_instr_lower =
      lookup_instr_addr[`RCS_PART_HI:`RCS_PART_LO] <= partition_index;
   wire logic lk_data_lower =
      lookup_data_addr[`RCS_PART_HI:`RCS_PART_LO] <= partition_index;

   // scan decision per address, from latched state only
   wire logic scan_addr_prot =
      (prot == rcs_pkg::RCS_PROT_GLOBAL) ||
      ((prot == rcs_pkg::RCS_PROT_BLOCK) && scan_lower);
   // writing the word once block mode is on may only clear global lock
   wire logic word_write = scan_we &&
      (scan_addr == `RCS_PROT_WORD_ADDR);
   wire logic word_write_ok = !word_write ||
      (prot != rcs_pkg::RCS_PROT_BLOCK) ||
      ((scan_wdata | `RCS_GLOBAL_MASK) ==
       (word_r | `RCS_GLOBAL_MASK));
   wire logic scan_ok = running && !scan_addr_prot && word_write_ok;

   // lookups: must not cross blocks while block protection holds
   wire logic same_block = (lk_instr_lower == lk_data_lower);
   wire logic lookup_pass = running &&
      ((prot != rcs_pkg::RCS_PROT_BLOCK) || same_block);

   // apb decode
   wire logic apb_setup = psel && !penable;
   wire logic apb_done = psel && penable && pready_r;
   wire logic [3:0] reg_off = paddr[3:0];
   wire logic hit_ctrl = (paddr[31:4] == 28'h000_0000) &&
      (reg_off == `RCS_OFF_CTRL);
   wire logic hit_status = (paddr[31:4] == 28'h000_0000) &&
      (reg_off == `RCS_OFF_STATUS);
   wire logic hit_word = (paddr[31:4] == 28'h000_0000) &&
      (reg_off == `RCS_OFF_WORD);
   wire logic mapped = hit_ctrl || hit_status || hit_word;
   wire logic ctrl_wr = apb_done && pwrite && hit_ctrl;
   wire rcs_pkg::rcs_mode_t req_mode = rcs_pkg::rcs_mode_t'(
      pwdata[`RCS_CTRL_MODE_HI:`RCS_CTRL_MODE_LO]);
   // a mode change or explicit reinit written to ctrl while running reruns the security check
   wire logic init_req = ctrl_wr && running &&
      ((req_mode != mode_r) || pwdata[`RCS_CTRL_REINIT]);
   // vpp drop leaves trace for emulation with the word still latched
   wire logic vpp_drop = running && vpp_low &&
      (mode_r == rcs_pkg::RCS_MODE_TRACE);

   wire logic [31:0] status_val = {27'h000_0000, prot, !running, mode_r};
   wire logic [31:0] rd_val =
      hit_ctrl ? {30'h0000_0000, pend_mode_r} :
      hit_status ? status_val :
      hit_word ? {15'h0000, word_r} : 32'h0000_0000;

   // init sequencer and mode tracking
   always_comb begin
      state_nxt = state_r;
      mode_nxt = mode_r;
      pend_mode_nxt = pend_mode_r;
      unique case (state_r)
         rcs_pkg::RCS_ST_READ: state_nxt = rcs_pkg::RCS_ST_CAPT;
         rcs_pkg::RCS_ST_CAPT: begin
            state_nxt = rcs_pkg::RCS_ST_RUN;
            mode_nxt = pend_mode_r; // mode entered only after the check
         end
         rcs_pkg::RCS_ST_RUN: begin
            if (init_req) begin
               state_nxt = rcs_pkg::RCS_ST_READ;
               pend_mode_nxt = req_mode;
            end else if (vpp_drop) begin
               mode_nxt = rcs_pkg::RCS_MODE_EMUL;
               pend_mode_nxt = rcs_pkg::RCS_MODE_EMUL;
            end
         end
         default: state_nxt = rcs_pkg::RCS_ST_READ;
      endcase
   end

   // sequencer flops; reset starts the power-up read at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= rcs_pkg::RCS_ST_READ;
         mode_r <= rcs_pkg::RCS_MODE_NORMAL;
         pend_mode_r <= rcs_pkg::RCS_MODE_NORMAL;
      end else begin
         state_r <= state_nxt;
         mode_r <= mode_nxt;
         pend_mode_r <= pend_mode_nxt;
      end
   end

   // protection word latch; erased default until the first capture
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         word_r <= `RCS_ERASED_WORD;
         // strobe held in reset so the power-up read is already issued
         rd_en_r <= 1'b1;
      end else begin
         rd_en_r <= (state_nxt == rcs_pkg::RCS_ST_READ);
         if (state_r == rcs_pkg::RCS_ST_CAPT) begin
            word_r <= rom_rdata;
         end
      end
   end

   // per-access decisions, one cycle after the request, and the lookup_external flag in step with mode_r
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scan_grant_r <= 1'b0;
         scan_deny_r <= 1'b0;
         lookup_ok_r <= 1'b0;
         lookup_fault_r <= 1'b0;
         lookup_ext_r <= 1'b0;
      end else begin
         scan_grant_r <= scan_req && scan_ok;
         scan_deny_r <= scan_req && !scan_ok;
         lookup_ok_r <= lookup_req && lookup_pass;
         lookup_fault_r <= lookup_req && !lookup_pass;
         lookup_ext_r <= (mode_nxt == rcs_pkg::RCS_MODE_EMUL);
      end
   end

   // apb slave: no wait states, answer registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         pready_r <= apb_setup;
         if (apb_setup) begin
            prdata_r <= pwrite ? 32'h0000_0000 : rd_val;
            // the latched word is never writable from software
            pslverr_r <= !mapped || (pwrite && !hit_ctrl);
         end
      end
   end

   // outputs straight from flops, except rom_addr tied to the constant word address and core_stall decoded from state_r
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign rom_addr = `RCS_PROT_WORD_ADDR;
   assign rom_rd_en = rd_en_r;
   assign core_stall = !running; // state_r is a flop, no decode glitch
   assign scan_grant = scan_grant_r;
   assign scan_deny = scan_deny_r;
   assign lookup_ok = lookup_ok_r;
   assign lookup_fault = lookup_fault_r;
   assign lookup_external = lookup_ext_r;
   assign mode = mode_r;

   // checks beside the logic
   a_init_stall: assert property (
      @(posedge pclk) disable iff (!presetn)
      init_req |=> core_stall [*2] ##1 !core_stall)
      else $error("init did not stall core for two cycles");

   // stall only ever starts from an accepted init request
   a_stall_cause: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(core_stall) |-> $past(init_req))
      else $error("stall raised without init request");

   a_read_issued: assert property (
      @(posedge pclk) disable iff (!presetn)
      state_r == rcs_pkg::RCS_ST_CAPT |-> $past(rom_rd_en))
      else $error("capture without rom read");

   a_stall_quiet: assert property (
      @(posedge pclk) disable iff (!presetn)
      core_stall |=> !scan_grant && !lookup_ok)
      else $error("access granted during init");

   a_global_deny: assert property (
      @(posedge pclk) disable iff (!presetn)
      scan_req && prot == rcs_pkg::RCS_PROT_GLOBAL |=> scan_deny)
      else $error("scan granted under global protection");

   // exactly one answer per scan request
   a_scan_answer: assert property (
      @(posedge pclk) disable iff (!presetn)
      scan_req |=> scan_grant != scan_deny)
      else $error("scan answer not one-hot");

   a_open_grant: assert property (
      @(posedge pclk) disable iff (!presetn)
      scan_req && running && !scan_we &&
      prot == rcs_pkg::RCS_PROT_NONE |=> scan_grant)
      else $error("scan read denied without protection");

   a_open_lookup: assert property (
      @(posedge pclk) disable iff (!presetn)
      lookup_req && running &&
      prot == rcs_pkg::RCS_PROT_NONE |=> lookup_ok)
      else $error("lookup refused without protection");

   a_block_edge: assert property (
      @(posedge pclk) disable iff (!presetn)
      scan_req && running && !scan_we &&
      prot == rcs_pkg::RCS_PROT_BLOCK |=>
      scan_grant == ($past(scan_addr) >=
      {$past(partition_index) + 6'h01, 9'h000}) ||
      ($past(partition_index) == 6'h3f && !scan_grant))
      else $error("block boundary decision wrong");

   a_word_steady: assert property (
      @(posedge pclk) disable iff (!presetn)
      running && $past(running) |-> $stable(word_r))
      else $error("protection word changed outside init");

   a_mode_via_init: assert property (
      @(posedge pclk) disable iff (!presetn)
      $changed(mode_r) && !$past(vpp_drop) |->
      $past(state_r) == rcs_pkg::RCS_ST_CAPT)
      else $error("mode changed without security check");

   a_vpp_keep: assert property (
      @(posedge pclk) disable iff (!presetn)
      vpp_drop && !init_req |=> mode_r == rcs_pkg::RCS_MODE_EMUL &&
      $stable(word_r) && running)
      else $error("vpp drop disturbed protection");

   a_lookup_cross: assert property (
      @(posedge pclk) disable iff (!presetn)
      lookup_req && prot == rcs_pkg::RCS_PROT_BLOCK && !same_block
      |=> lookup_fault && !lookup_ok)
      else $error("cross-block lookup allowed");

   a_lookup_answer: assert property (
      @(posedge pclk) disable iff (!presetn)
      lookup_req |=> lookup_ok != lookup_fault)
      else $error("lookup answer not one-hot");

   a_emul_ext: assert property (
      @(posedge pclk) disable iff (!presetn)
      mode_r == rcs_pkg::RCS_MODE_EMUL |-> lookup_external)
      else $error("emulation lookup not external");

   a_ext_follow: assert property (
      @(posedge pclk) disable iff (!presetn)
      lookup_external |-> mode_r == rcs_pkg::RCS_MODE_EMUL)
      else $error("external lookup outside emulation");

   a_word_lock: assert property (
      @(posedge pclk) disable iff (!presetn)
      scan_req && word_write && prot == rcs_pkg::RCS_PROT_BLOCK &&
      scan_wdata[`RCS_TRUE_HI:`RCS_TRUE_LO] != partition_index
      |=> scan_deny)
      else $error("partition rewrite allowed");

   a_word_ro: assert property (
      @(posedge pclk) disable iff (!presetn)
      psel && !penable && pwrite && !hit_ctrl |=> pslverr)
      else $error("software write outside ctrl accepted");

endmodule // rcs_rom_security

/* tb/rcs_rom_model.sv */
/*
 * partner model of the rom array cell holding the protection word.
 * assumes the bench programs and erases it between security inits.
 */
`timescale 1ns/100ps

module rcs_rom_model (
   input wire logic pclk,
   input wire logic [14:0] rom_addr,
   input wire logic rom_rd_en,
   output logic [16:0] rom_rdata,
   input wire logic pgm_en,
   input wire logic [16:0] pgm_data,
   input wire logic erase
);
   logic [16:0] word_r = 17'h1_ffff;

   // non-volatile, so reset leaves it alone; program only clears bits
   always @(posedge pclk) begin
      if (erase) begin
         word_r <= 17'h1_ffff;
      end else if (pgm_en) begin
         word_r <= word_r & pgm_data;
      end
   end

   // one 17-bit word at 15'h7ffe and its complement at any other address, answered the cycle after the strobe
   always @(posedge pclk) begin
      if (rom_rd_en) begin
         rom_rdata <= (rom_addr == 15'h7ffe) ? word_r : ~word_r;
      end
   end
endmodule // rcs_rom_model

/* tb/test_rom_code_security.sv */
/*
 * self-checking bench for rcs_rom_security with an apb master.
 * assumes rcs_rom_model stands for the rom array.
 */
`timescale 1ns/100ps
`include "rcs_rom_security_regs.svh"

module test_rom_code_security;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic [14:0] rom_addr, scan_addr, li_addr, ld_addr;
   logic [16:0] rom_rdata, scan_wdata, pgm_data;
   logic rom_rd_en, core_stall, vpp_low, scan_req, scan_we, scan_grant;
   logic scan_deny, lookup_req, lookup_ok, lookup_fault, lookup_external;
   logic pgm_en, erase;
   logic [1:0] mode;
   int failures, n_compared, cycles;

   rcs_rom_security rcs_rom_security_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rom_addr(rom_addr), .rom_rd_en(rom_rd_en),
      .rom_rdata(rom_rdata), .core_stall(core_stall), .vpp_low(vpp_low),
      .scan_req(scan_req), .scan_we(scan_we), .scan_addr(scan_addr),
      .scan_wdata(scan_wdata), .scan_grant(scan_grant),
      .scan_deny(scan_deny), .lookup_req(lookup_req),
      .lookup_instr_addr(li_addr), .lookup_data_addr(ld_addr),
      .lookup_ok(lookup_ok), .lookup_fault(lookup_fault),
      .lookup_external(lookup_external), .mode(mode));

   rcs_rom_model rcs_rom_model_i (.pclk(pclk), .rom_addr(rom_addr),
      .rom_rd_en(rom_rd_en), .rom_rdata(rom_rdata), .pgm_en(pgm_en),
      .pgm_data(pgm_data), .erase(erase));

   // free-running clock and a hang guard
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 5000) begin
         mism("timeout");
         stop_test();
      end
   end

   task automatic mism(input string m);
      failures++;
      $display("mismatch at %0t: %s", $time, m);
   endtask
   task automatic chk_bit(input logic got, input logic exp, input string m);
      n_compared++;
      if (got !== exp) mism(m);
   endtask
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp,
         input string m);
      n_compared++;
      if (got !== exp) mism(m);
   endtask
   task automatic stop_test();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // apb master: request held until pready is sampled high
   task automatic apb(input logic wr, input logic [31:0] a,
         input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no latency assumed; only the bench timeout ends this wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_run();
      int w;
      w = 0;
      while (core_stall !== 1'b0 && w < 10) begin
         @(posedge pclk);
         #1 w++;
      end
      chk_bit(core_stall, 1'b0, "stall stuck");
   endtask

   // mode must not move before the rerun init finishes
   task automatic reinit(input logic [31:0] v);
      logic [1:0] old;
      old = mode;
      apb(1'b1, 32'(`RCS_OFF_CTRL), v);
      #1 chk_bit(core_stall, 1'b1, "no init");
      chk_word({30'h0, mode}, {30'h0, old}, "mode jumped");
      wait_run();
   endtask

   task automatic chk_st(input logic [1:0] m, input logic [1:0] p);
      apb(1'b0, 32'(`RCS_OFF_STATUS), 32'h0);
      chk_word(rd & 32'h0000_001f, {27'h0, p, 1'b0, m}, "status");
   endtask

   task automatic nv(input logic er, input logic [16:0] w);
      @(posedge pclk);
      erase <= er;
      pgm_en <= !er;
      pgm_data <= w;
      @(posedge pclk);
      erase <= 1'b0;
      pgm_en <= 1'b0;
   endtask

   // grant and deny are a one-cycle pulse after the request
   task automatic scan(input logic we, input logic [14:0] a, input logic g);
      @(posedge pclk);
      scan_req <= 1'b1;
      scan_we <= we;
      scan_addr <= a;
      scan_wdata <= 17'h0_0000;
      @(posedge pclk);
      scan_req <= 1'b0;
      #1 chk_bit(scan_grant, g, "grant");
      chk_bit(scan_deny, !g, "deny");
   endtask

   task automatic look(input logic [14:0] i, input logic [14:0] d,
         input logic ok);
      @(posedge pclk);
      lookup_req <= 1'b1;
      li_addr <= i;
      ld_addr <= d;
      @(posedge pclk);
      lookup_req <= 1'b0;
      #1 chk_bit(lookup_ok, ok, "lookup ok");
      chk_bit(lookup_fault, !ok, "lookup fault");
   endtask

   function automatic logic [16:0] mk(input logic [5:0] n, input logic g,
         input logic b);
      return {2'b11, n, g, b, 1'b1, ~n};
   endfunction

   task automatic t_power();
      chk_st(rcs_pkg::RCS_MODE_NORMAL, rcs_pkg::RCS_PROT_NONE);
      apb(1'b0, 32'(`RCS_OFF_WORD), 32'h0);
      chk_word(rd, 32'h0001_ffff, "word");
      scan(1'b0, 15'h0000, 1'b1);
      scan(1'b1, 15'h7fff, 1'b1);
      look(15'h0000, 15'h7fff, 1'b1);
      apb(1'b0, 32'h0000_000c, 32'h0);
      chk_word({31'h0, err}, 32'h0000_0001, "unmapped err");
      chk_word(rd, 32'h0000_0000, "unmapped data");
      apb(1'b1, 32'(`RCS_OFF_STATUS), 32'h0000_0003);
      chk_bit(err, 1'b1, "status write");
      $display("test power done");
   endtask

   // partition at both ends of the index range and in between
   task automatic t_block(input logic [5:0] n);
      int b;
      b = (int'(n) + 1) * 512;
      nv(1'b1, 17'h0_0000);
      nv(1'b0, mk(n, 1'b1, 1'b0));
      reinit(32'h0000_0004);
      chk_st(rcs_pkg::RCS_MODE_NORMAL, rcs_pkg::RCS_PROT_BLOCK);
      scan(1'b0, 15'h0000, 1'b0);
      scan(1'b1, 15'(b - 1), 1'b0);
      look(15'h0000, 15'(b - 1), 1'b1);
      if (b < 32768) begin
         scan(1'b0, 15'(b), 1'b1);
         look(15'h0000, 15'(b), 1'b0);
      end else begin
         scan(1'b0, 15'h7fff, 1'b0);
      end
      $display("test block %0d done", n);
   endtask

   // lowering more marker bits breaks parity instead of moving it
   task automatic t_relock();
      scan(1'b1, 15'h7ffe, 1'b0);
      nv(1'b0, 17'h1_fdff);
      reinit(32'h0000_0004);
      chk_st(rcs_pkg::RCS_MODE_NORMAL, rcs_pkg::RCS_PROT_GLOBAL);
      nv(1'b1, 17'h0_0000);
      nv(1'b0, mk(6'h00, 1'b0, 1'b1));
      reinit(32'h0000_0004);
      chk_st(rcs_pkg::RCS_MODE_NORMAL, rcs_pkg::RCS_PROT_GLOBAL);
      scan(1'b0, 15'h7fff, 1'b0);
      $display("test relock done");
   endtask

   task automatic t_modes();
      logic [1:0] seq [4] = '{2'd1, 2'd3, 2'd2, 2'd3};
      nv(1'b1, 17'h0_0000);
      nv(1'b0, mk(6'h05, 1'b1, 1'b0));
      foreach (seq[k]) begin
         reinit({30'h0, seq[k]});
         chk_st(seq[k], rcs_pkg::RCS_PROT_BLOCK);
         chk_bit(lookup_external, seq[k] == 2'd2, "ext");
      end
      @(posedge pclk);
      vpp_low <= 1'b1;
      repeat (3) @(posedge pclk);
      #1 chk_word({30'h0, mode}, 32'h0000_0002, "vpp drop");
      chk_st(rcs_pkg::RCS_MODE_EMUL, rcs_pkg::RCS_PROT_BLOCK);
      chk_bit(lookup_external, 1'b1, "ext after vpp");
      apb(1'b0, 32'(`RCS_OFF_CTRL), 32'h0);
      chk_word(rd, 32'h0000_0002, "pending mode");
      scan(1'b0, 15'h0000, 1'b0);
      @(posedge pclk);
      vpp_low <= 1'b0;
      $display("test modes done");
   endtask

   // reset, then the scenarios in turn
   initial begin
      {psel, penable, pwrite, scan_req, scan_we, lookup_req} = '0;
      {presetn, vpp_low, pgm_en, erase} = '0;
      {paddr, pwdata} = '0;
      {scan_addr, li_addr, ld_addr, scan_wdata, pgm_data} = '0;
      {failures, n_compared, cycles} = '0;
      repeat (2) @(posedge pclk);
      #1 chk_bit(core_stall, 1'b1, "stall in reset");
      @(posedge pclk);
      presetn <= 1'b1;
      wait_run();
      t_power();
      t_block(6'h00);
      t_block(6'h05);
      t_relock();
      t_block(6'h3f);
      t_modes();
      stop_test();
   end
endmodule // test_rom_code_security
